// File: rtl/sag_pkg.sv
// Summary of operation
// RQ1: Physical address is segment shifted left four bits plus offset, twenty bits wide.
// RQ2: Memory addresses pair a 16-bit segment from four segment registers with an offset.
// RQ3: Fetches and immediates use code segment; ordinary data uses data segment.
// RQ4: Stack pushes and pops use the stack segment.
// RQ5: References based on the base pointer default to the stack segment.
// RQ6: String references indexed by destination index use the extra segment.
// RQ7: Separate I/O space of 64K bytes or 32K words, reached only by I/O instructions.
// RQ8: Port address comes from an 8-bit instruction field or the port address register.
// RQ9: An 8-bit port field is zero-extended so the upper eight address bits are low.
// RQ10: Carry out of bit 19 is dropped so addresses wrap within one megabyte.
package sag_pkg;
    localparam int SEG_W        = 16;
    localparam int OFS_W        = 16;
    localparam int PHYS_W       = 20;
    localparam int SEG_SHIFT    = 4;
    localparam int PORT_W       = 16;
    localparam int PORT_FIELD_W = 8;

    typedef enum logic [2:0] {
        SAG_REF_FETCH,
        SAG_REF_DATA,
        SAG_REF_STACK,
        SAG_REF_STRING_DEST,
        SAG_REF_IO
    } sag_ref_t;

    typedef enum logic [1:0] {
        SAG_SEG_CODE,
        SAG_SEG_DATA,
        SAG_SEG_STACK,
        SAG_SEG_EXTRA
    } sag_seg_t;
endpackage : sag_pkg

// File: rtl/sag_phys_add.sv
`timescale 1ns/1ps
module sag_phys_add
    import sag_pkg::*;
(
    // Operands.
    input  wire logic [SEG_W-1:0]  seg,
    input  wire logic [OFS_W-1:0]  ofs,
    // Result.
    output logic      [PHYS_W-1:0] phys
);
    wire logic [PHYS_W-1:0] seg_shifted;
    wire logic [PHYS_W-1:0] ofs_ext;

    assign seg_shifted = {seg, {SEG_SHIFT{1'b0}}}; // RQ1
    assign ofs_ext     = {{(PHYS_W-OFS_W){1'b0}}, ofs};
    // The sum is kept at twenty bits so any carry out of the top bit is lost.
    assign phys        = seg_shifted + ofs_ext; // RQ10
endmodule : sag_phys_add

// File: rtl/sag_top.sv
`timescale 1ns/1ps
module sag_top
    import sag_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // Request from the decoder.
    input  wire logic                    req_valid,
    input  wire sag_ref_t                ref_kind,
    input  wire logic                    uses_base_pointer_reg,
    input  wire logic [OFS_W-1:0]        offset,
    input  wire logic                    io_word,
    input  wire logic                    io_port_from_gpr,
    input  wire logic [PORT_FIELD_W-1:0] io_port_field,
    // Register file values.
    input  wire logic [SEG_W-1:0]        code_segment_reg,
    input  wire logic [SEG_W-1:0]        data_segment_reg,
    input  wire logic [SEG_W-1:0]        stack_segment_reg,
    input  wire logic [SEG_W-1:0]        extra_segment_reg,
    input  wire logic [PORT_W-1:0]       port_addr_gpr,
    // Toward the bus interface unit.
    output logic                         mem_valid,
    output logic [PHYS_W-1:0]            mem_addr,
    output sag_seg_t                     mem_seg,
    output logic                         io_valid,
    output logic [PORT_W-1:0]            io_addr,
    output logic                         io_word_q
);
    wire sag_seg_t          seg_sel;
    wire logic [SEG_W-1:0]  seg_val;
    wire logic [PHYS_W-1:0] phys;
    wire logic [PORT_W-1:0] port_addr;
    wire logic              is_io;
    wire logic              mem_take;
    wire logic              kind_fetch;
    wire logic              kind_data;
    wire logic              kind_stack;
    wire logic              kind_dest;
    wire logic              kind_io;
    wire logic [SEG_W-1:0]  seg_bank [4];
    wire logic [SEG_W-1:0]  seg_pick [4];

    // The adder relies on the shifted segment filling the physical width exactly.
    if (PHYS_W != SEG_W + SEG_SHIFT) begin : g_bad_phys_w
        $error("physical width must equal segment width plus shift");
    end
    // The offset must be narrower than the sum and the port field must leave room to zero-extend.
    if (OFS_W >= PHYS_W || PORT_FIELD_W >= PORT_W) begin : g_bad_narrow_w
        $error("offset or port field too wide for its target");
    end

    // One-hot decode of the reference kind.
    assign kind_fetch = (ref_kind == SAG_REF_FETCH);
    assign kind_data  = (ref_kind == SAG_REF_DATA);
    assign kind_stack = (ref_kind == SAG_REF_STACK);
    assign kind_dest  = (ref_kind == SAG_REF_STRING_DEST);
    assign kind_io    = (ref_kind == SAG_REF_IO);

    // Segment chosen implicitly by the kind of reference.
    assign seg_sel = kind_fetch            ? SAG_SEG_CODE :  // RQ3
                     kind_stack            ? SAG_SEG_STACK : // RQ4
                     kind_dest             ? SAG_SEG_EXTRA : // RQ6
                     uses_base_pointer_reg ? SAG_SEG_STACK : // RQ5
                                             SAG_SEG_DATA;   // RQ3

    // The four segment registers form a bank; the selected entry is picked by compare and OR.
    assign seg_bank[SAG_SEG_CODE]  = code_segment_reg;  // RQ2
    assign seg_bank[SAG_SEG_DATA]  = data_segment_reg;
    assign seg_bank[SAG_SEG_STACK] = stack_segment_reg;
    assign seg_bank[SAG_SEG_EXTRA] = extra_segment_reg;
    for (genvar s = 0; s < 4; s++) begin : g_seg
        assign seg_pick[s] = (seg_sel == 2'(s)) ? seg_bank[s] : '0;
    end
    assign seg_val = seg_pick[0] | seg_pick[1] | seg_pick[2] | seg_pick[3];

    sag_phys_add u_add (
        .seg  (seg_val),
        .ofs  (offset),
        .phys (phys)
    );

    // Only the I/O reference kind reaches the port space.
    assign is_io     = req_valid && kind_io;  // RQ7
    assign mem_take  = req_valid && !kind_io; // RQ7
    assign port_addr = io_port_from_gpr ? port_addr_gpr :                         // RQ8
                       {{(PORT_W-PORT_FIELD_W){1'b0}}, io_port_field};            // RQ9

    // The two strobes follow only the request of the previous edge, so back-to-back requests hold them high for several cycles.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_valid <= 1'b0;
            io_valid  <= 1'b0;
        end else begin
            mem_valid <= mem_take; // RQ7
            io_valid  <= is_io;    // RQ7
        end
    end

    // The memory address and segment stand until the next memory request replaces them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_addr <= '0;
            mem_seg  <= SAG_SEG_CODE;
        end else if (mem_take) begin
            mem_addr <= phys;    // RQ1
            mem_seg  <= seg_sel; // RQ3
        end
    end

    // The port address and width stand until the next I/O request replaces them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_addr   <= '0;
            io_word_q <= 1'b0;
        end else if (is_io) begin
            io_addr   <= port_addr; // RQ8
            io_word_q <= io_word;   // RQ7
        end
    end

    phys_form_a: assert property (@(posedge clk) disable iff (!nrst) // RQ1
        (req_valid && ref_kind == SAG_REF_DATA && !uses_base_pointer_reg) |=>
        mem_addr == PHYS_W'(({4'h0, $past(data_segment_reg)} << SEG_SHIFT) + $past(offset)))
        else $error("physical address wrong");

    fetch_seg_a: assert property (@(posedge clk) disable iff (!nrst) // RQ3
        (req_valid && ref_kind == SAG_REF_FETCH) |=> (mem_valid && mem_seg == SAG_SEG_CODE))
        else $error("fetch not on code segment");

    stack_seg_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (req_valid && ref_kind == SAG_REF_STACK) |=> (mem_valid && mem_seg == SAG_SEG_STACK))
        else $error("stack not on stack segment");

    bp_seg_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
        (req_valid && ref_kind == SAG_REF_DATA && uses_base_pointer_reg) |=> mem_seg == SAG_SEG_STACK)
        else $error("base pointer not on stack segment");

    dest_seg_a: assert property (@(posedge clk) disable iff (!nrst) // RQ6
        (req_valid && ref_kind == SAG_REF_STRING_DEST) |=> mem_seg == SAG_SEG_EXTRA)
        else $error("string dest not on extra segment");

    io_excl_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        !(io_valid && mem_valid))
        else $error("io and memory both valid");

    io_gpr_a: assert property (@(posedge clk) disable iff (!nrst) // RQ8
        (is_io && io_port_from_gpr) |=> (io_valid && io_addr == $past(port_addr_gpr)))
        else $error("port address not from register");

    io_zext_a: assert property (@(posedge clk) disable iff (!nrst) // RQ9
        (is_io && !io_port_from_gpr) |=> io_addr[PORT_W-1:PORT_FIELD_W] == 8'h00)
        else $error("port field not zero extended");

    // Checks on the port address and width.
    io_field_a: assert property (@(posedge clk) disable iff (!nrst) // RQ9
        (is_io && !io_port_from_gpr) |=> io_addr == PORT_W'($past(io_port_field)))
        else $error("port field not carried to the port address");

    io_width_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        is_io |=> io_word_q == $past(io_word))
        else $error("port width not carried");

    // Checks on the strobes.
    io_only_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        is_io |=> (io_valid && !mem_valid))
        else $error("io request reached memory");

    mem_only_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        mem_take |=> (mem_valid && !io_valid))
        else $error("memory request reached io space");

    idle_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        !req_valid |=> (!mem_valid && !io_valid))
        else $error("strobe without a request");

    // Checks on the segment chosen for each kind.
    data_seg_a: assert property (@(posedge clk) disable iff (!nrst) // RQ3
        (req_valid && kind_data && !uses_base_pointer_reg) |=> (mem_valid && mem_seg == SAG_SEG_DATA))
        else $error("data not on data segment");

    fetch_bp_a: assert property (@(posedge clk) disable iff (!nrst) // RQ3
        (req_valid && kind_fetch && uses_base_pointer_reg) |=> mem_seg == SAG_SEG_CODE)
        else $error("base pointer moved a fetch off the code segment");

    stack_bp_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (req_valid && kind_stack && uses_base_pointer_reg) |=> mem_seg == SAG_SEG_STACK)
        else $error("base pointer moved a stack access off the stack segment");

    dest_bp_a: assert property (@(posedge clk) disable iff (!nrst) // RQ6
        (req_valid && kind_dest && uses_base_pointer_reg) |=> mem_seg == SAG_SEG_EXTRA)
        else $error("base pointer moved a string dest off the extra segment");

    // Checks on the address formed from the code, stack and extra segment registers.
    code_addr_a: assert property (@(posedge clk) disable iff (!nrst) // RQ2
        (req_valid && kind_fetch) |=>
        mem_addr == PHYS_W'(({4'h0, $past(code_segment_reg)} << SEG_SHIFT) + $past(offset)))
        else $error("fetch address not from code segment");

    stack_addr_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (req_valid && kind_stack) |=>
        mem_addr == PHYS_W'(({4'h0, $past(stack_segment_reg)} << SEG_SHIFT) + $past(offset)))
        else $error("stack address not from stack segment");

    bp_addr_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
        (req_valid && kind_data && uses_base_pointer_reg) |=>
        mem_addr == PHYS_W'(({4'h0, $past(stack_segment_reg)} << SEG_SHIFT) + $past(offset)))
        else $error("base pointer address not from stack segment");

    extra_addr_a: assert property (@(posedge clk) disable iff (!nrst) // RQ6
        (req_valid && kind_dest) |=>
        mem_addr == PHYS_W'(({4'h0, $past(extra_segment_reg)} << SEG_SHIFT) + $past(offset)))
        else $error("string dest address not from extra segment");

    addr_wrap_a: assert property (@(posedge clk) disable iff (!nrst) // RQ10
        mem_take |=> mem_addr == PHYS_W'((21'($past(seg_val)) << SEG_SHIFT) + 21'($past(offset))))
        else $error("carry out of the physical address kept");

    wrap_hit_a: assert property (@(posedge clk) disable iff (!nrst) // RQ10
        (mem_take && seg_val == 16'hffff && offset >= 16'h0010) |=> mem_addr == PHYS_W'($past(offset) - 16'h0010))
        else $error("top segment address did not wrap");

    // Memory address, segment, port address and port width stand until the next request of their own space.
    mem_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RQ1
        !mem_take |=> ($stable(mem_addr) && $stable(mem_seg)))
        else $error("memory address changed without a request");

    io_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RQ8
        !is_io |=> ($stable(io_addr) && $stable(io_word_q)))
        else $error("port address changed without a request");
endmodule : sag_top

// File: verif/sag_biu_model.sv
`timescale 1ns/1ps
module sag_biu_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic nrst,
    // Cycle starts from the address generator.
    input  wire logic mem_valid,
    input  wire logic io_valid,
    // Bus cycles run so far.
    output int        mem_cycles,
    output int        io_cycles
);
    // Each clock cycle with a valid high starts exactly one bus cycle of its space.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_cycles <= 0;
            io_cycles  <= 0;
        end else begin
            mem_cycles <= mem_cycles + int'(mem_valid);
            io_cycles  <= io_cycles + int'(io_valid);
        end
    end
endmodule : sag_biu_model

// File: verif/test_segment_address_generator.sv
`timescale 1ns/1ps
module test_segment_address_generator;
    import sag_pkg::*;
    logic clk, nrst, req_valid, uses_base_pointer_reg, io_word, io_port_from_gpr, mem_valid, io_valid, io_word_q;
    logic [15:0] offset, code_segment_reg, data_segment_reg, stack_segment_reg, extra_segment_reg, port_addr_gpr, io_addr;
    logic [7:0] io_port_field;
    logic [19:0] mem_addr, ea;
    sag_ref_t ref_kind, k;
    sag_seg_t mem_seg, eseg;
    logic [15:0] sg[4], o, g, eia;
    logic [31:0] v;
    logic em, ei, eiw;
    int seed = 32'h1e23, bad_count = 0, samples_checked = 0, nm = 0, ni = 0, mem_cycles, io_cycles;
    sag_top u_dut (.clk, .nrst, .req_valid, .ref_kind, .uses_base_pointer_reg, .offset, .io_word, .io_port_from_gpr,
        .io_port_field, .code_segment_reg, .data_segment_reg, .stack_segment_reg, .extra_segment_reg, .port_addr_gpr,
        .mem_valid, .mem_addr, .mem_seg, .io_valid, .io_addr, .io_word_q);
    sag_biu_model u_biu (.clk, .nrst, .mem_valid, .io_valid, .mem_cycles, .io_cycles);
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    function automatic sag_seg_t sel(sag_ref_t r, logic bp);
        if (r == SAG_REF_FETCH) return SAG_SEG_CODE;
        if (r == SAG_REF_STACK || (r == SAG_REF_DATA && bp)) return SAG_SEG_STACK;
        return (r == SAG_REF_STRING_DEST) ? SAG_SEG_EXTRA : SAG_SEG_DATA;
    endfunction : sel
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(4 * 3000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {nrst, req_valid, uses_base_pointer_reg, io_word, io_port_from_gpr, offset, io_port_field} = '0;
        {code_segment_reg, data_segment_reg, stack_segment_reg, extra_segment_reg, port_addr_gpr} = '0;
        ref_kind = SAG_REF_FETCH;
        {em, ei, eiw, ea, eia} = '0;
        eseg = SAG_SEG_CODE;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // The first ten requests cover every kind twice with all-ones segment and offset to force the wrap.
        for (int i = 0; i <= 400; i++) begin
            @(posedge clk);
            k = (i < 10) ? sag_ref_t'(3'(i % 5)) : sag_ref_t'(3'($unsigned($random(seed)) % 5));
            v = $random(seed);
            if (i < 10) v[0] = 1'b1;
            o = (i < 10) ? 16'hffff : 16'($random(seed));
            g = 16'($random(seed));
            foreach (sg[j]) sg[j] = (i < 10) ? 16'hffff : 16'($random(seed));
            req_valid <= v[0] && i < 400;
            ref_kind <= k;
            {io_port_field, io_port_from_gpr, io_word, uses_base_pointer_reg} <= v[11:1];
            {offset, port_addr_gpr} <= {o, g};
            {code_segment_reg, data_segment_reg, stack_segment_reg, extra_segment_reg} <= {sg[0], sg[1], sg[2], sg[3]};
            #1;
            chk(mem_valid === em && io_valid === ei, "valid pulse");
            chk(mem_addr === ea, "mem_addr");
            chk(mem_seg === eseg, "mem_seg");
            chk(io_addr === eia && io_word_q === eiw, "io port");
            em = v[0] && i < 400 && k != SAG_REF_IO;
            ei = v[0] && i < 400 && k == SAG_REF_IO;
            if (em) eseg = sel(k, v[1]);
            if (em) ea = 20'({4'h0, sg[eseg]} << 4) + 20'(o);
            if (ei) eia = v[3] ? g : {8'h00, v[11:4]};
            if (ei) eiw = v[2];
            nm += int'(em);
            ni += int'(ei);
        end
        @(posedge clk);
        #1;
        chk(mem_cycles == nm && io_cycles == ni, "cycle count");
        $display("random address test done");
        tally_and_finish();
    end
endmodule : test_segment_address_generator
